// *** rtl/aoc_regs.vh ***
`ifndef AOC_REGS_VH
`define AOC_REGS_VH

// register byte offsets
`define AOC_ADDR_OFFSET 8'h00
`define AOC_ADDR_RESULT 8'h04
`define AOC_ADDR_IRQ_STAT 8'h08
`define AOC_ADDR_IRQ_MASK 8'h0c
`define AOC_ADDR_STATE 8'h10

// interrupt status / mask bit positions
`define AOC_IRQ_DONE 0
`define AOC_IRQ_RANGE 1
`define AOC_IRQ_EARLY 2
`define AOC_IRQ_REJECT 3
`define AOC_IRQ_W 4

// state register bit positions
`define AOC_ST_LIGHT 0
`define AOC_ST_DEEP 1
`define AOC_ST_BUSY 2
`define AOC_ST_SETTLED 3
`define AOC_ST_SAT 4
`define AOC_ST_W 5

// offset word layout
`define AOC_OFS_W 15
`define AOC_OFS_VAL_W 12
`define AOC_OFS_RESET 15'h0000

// result codes
`define AOC_CODE_W 14
`define AOC_RES_W 15
`define AOC_CODE_MAX 16'h3fff
`define AOC_CODE_MIN 16'h0000
`define AOC_RESULT_RESET 15'h0000

// timing, in nanoseconds
`define AOC_CLK_NS 100
`define AOC_LIGHT_WAKE_NS 100
`define AOC_DEEP_WAKE_NS 200000

`endif

// *** rtl/aoc_control.v ***
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "aoc_regs.vh"

// Function
// [RL1] light or deep sleep pin high puts the device in that mode
// [RL2] light sleep powers down everything except the voltage reference
// [RL3] host waits at least 100 ns after light sleep before converting
// [RL4] deep sleep powers down everything including the reference
// [RL5] host releases deep sleep 200 us before converting, else invalid
// [RL6] saturation on with zero offset gives plain 14-bit codes
// [RL7] saturated: above full scale all ones, below zero all zeros
// [RL8] saturated: bit fifteen flags input outside nominal span
// [RL9] nonzero offset added to raw result at end of conversion
// [RL10] saturation on clamps sum to 0x3fff maximum, 0x0000 minimum
// [RL11] range flag follows input voltage, not the clamping of the sum
// [RL12] offset is 15-bit word, low 12 signed, top 3 zero, kept; the code stores the top 3 bits as written
// [RL13] saturation off outputs the unclamped signed sum on 15 bits
// [RL14] falling edge of sample_start_n holds input and starts conversion
// [RL15] host counts power-up delay and holds off the start strobe
module aoc_control #(
	parameter DEEP_WAKE_NS = `AOC_DEEP_WAKE_NS,
	parameter RAW_W = 16
) (
	input wire clk, // 10 MHz clock
	input wire srst, // synchronous reset, active high
	input wire [7:0] bus_addr, // register byte address
	input wire [31:0] bus_wdata, // register write data
	input wire bus_wr, // write strobe
	input wire bus_rd, // read strobe
	output reg [31:0] bus_rdata, // read data, cycle after bus_rd
	output wire irq, // level interrupt
	input wire light_sleep_request, // pin: light power-down
	input wire deep_sleep_request, // pin: deep power-down
	input wire saturate_enable, // pin: clamp output codes
	input wire sample_start_n, // pin: conversion strobe, active low
	input wire sar_done, // analog core: approximation finished
	input wire [RAW_W-1:0] sar_raw, // analog core: signed raw code
	output reg core_power_en, // power to converter circuitry
	output reg ref_power_en, // power to voltage reference
	output reg hold_en, // track/hold in hold
	output reg sar_go, // one-cycle start to analog core
	output reg busy_n, // low while converting
	output reg [`AOC_RES_W-1:0] result_data // 15-bit result
);

	localparam LIGHT_WAKE_CYC =
		(`AOC_LIGHT_WAKE_NS + `AOC_CLK_NS - 1) / `AOC_CLK_NS;
	localparam DEEP_WAKE_CYC = (DEEP_WAKE_NS + `AOC_CLK_NS - 1) / `AOC_CLK_NS;
	localparam WAKE_W = 16;

	localparam ST_IDLE = 1'b0;
	localparam ST_CONV = 1'b1;

	// pin synchronisers: three flops, change accepted when 2nd and 3rd agree
	wire [3:0] pin_in;
	reg [3:0] sync1_r;
	reg [3:0] sync2_r;
	reg [3:0] sync3_r;
	reg [3:0] pin_r;
	assign pin_in = {sample_start_n, saturate_enable, deep_sleep_request,
		light_sleep_request};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
			always @(posedge clk) begin
				if (srst) begin
					sync1_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
					sync2_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
					sync3_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
					pin_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
				end else begin
					sync1_r[gi] <= pin_in[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
					if (sync2_r[gi] == sync3_r[gi]) begin
						pin_r[gi] <= sync3_r[gi];
					end
				end
			end
		end
	endgenerate

	wire light_s = pin_r[0];
	wire deep_s = pin_r[1];
	wire sat_s = pin_r[2];
	wire start_n_s = pin_r[3];
	reg start_n_d_r;
	wire start_fall = start_n_d_r & ~start_n_s;

	// power control
	always @(posedge clk) begin
		if (srst) begin
			core_power_en <= 1'b1;
			ref_power_en <= 1'b1;
		end else begin
			core_power_en <= ~(light_s | deep_s); // see [RL1] [RL2] [RL4]
			ref_power_en <= ~deep_s; // see [RL2] [RL4]
		end
	end

	// wake counters: device only reports settling, the host owns the wait
	reg [WAKE_W-1:0] wake_cnt_r;
	reg [WAKE_W-1:0] wake_cnt_nxt;
	reg was_deep_r;
	wire settled = (wake_cnt_r == {WAKE_W{1'b0}});

	always @* begin
		wake_cnt_nxt = wake_cnt_r;
		if (deep_s) begin
			wake_cnt_nxt = DEEP_WAKE_CYC[WAKE_W-1:0]; // see [RL5]
		end else if (light_s) begin
			if (!was_deep_r) begin
				wake_cnt_nxt = LIGHT_WAKE_CYC[WAKE_W-1:0]; // see [RL3]
			end
		end else if (!settled) begin
			wake_cnt_nxt = wake_cnt_r - {{(WAKE_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			wake_cnt_r <= {WAKE_W{1'b0}};
			was_deep_r <= 1'b0;
		end else begin
			wake_cnt_r <= wake_cnt_nxt;
			// light sleep right after deep keeps the longer reference wait
			if (deep_s) begin
				was_deep_r <= 1'b1;
			end else if (settled && !light_s) begin
				was_deep_r <= 1'b0;
			end
		end
	end

	// offset register and result arithmetic
	reg [`AOC_OFS_W-1:0] offset_r;
	wire signed [RAW_W-1:0] ofs_ext = {{(RAW_W-`AOC_OFS_VAL_W){
		offset_r[`AOC_OFS_VAL_W-1]}}, offset_r[`AOC_OFS_VAL_W-1:0]};
	wire signed [RAW_W-1:0] raw_s = sar_raw;
	wire signed [RAW_W-1:0] sum = raw_s + ofs_ext; // see [RL9]
	wire signed [RAW_W-1:0] code_max = `AOC_CODE_MAX;
	wire signed [RAW_W-1:0] code_min = `AOC_CODE_MIN;
	// flag from raw code: raw is the input voltage in nominal lsbs
	wire out_of_span = (raw_s < code_min) || (raw_s > code_max); // see [RL11]

	function [`AOC_RES_W-1:0] shape;
		input signed [RAW_W-1:0] s;
		input sat;
		input flag;
		begin
			if (!sat) begin
				shape = s[`AOC_RES_W-1:0]; // see [RL13]
			end else if (s > code_max) begin
				shape = {flag, code_max[`AOC_CODE_W-1:0]}; // see [RL7] [RL10]
			end else if (s < code_min) begin
				shape = {flag, code_min[`AOC_CODE_W-1:0]}; // see [RL7] [RL10]
			end else begin
				shape = {flag, s[`AOC_CODE_W-1:0]}; // see [RL6] [RL8]
			end
		end
	endfunction

	// conversion sequencer
	reg state_r;
	reg early_r;
	reg [`AOC_IRQ_W-1:0] ev;
	always @(posedge clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
			start_n_d_r <= 1'b1;
			hold_en <= 1'b0;
			sar_go <= 1'b0;
			busy_n <= 1'b1;
			early_r <= 1'b0;
			result_data <= `AOC_RESULT_RESET;
			ev <= {`AOC_IRQ_W{1'b0}};
		end else begin
			start_n_d_r <= start_n_s;
			sar_go <= 1'b0;
			ev <= {`AOC_IRQ_W{1'b0}};
			case (state_r)
			ST_IDLE: begin
				if (start_fall) begin
					if (light_s || deep_s) begin
						// no circuitry to convert with while asleep
						ev[`AOC_IRQ_REJECT] <= 1'b1;
					end else begin
						hold_en <= 1'b1; // see [RL14]
						sar_go <= 1'b1; // see [RL14]
						busy_n <= 1'b0;
						early_r <= ~settled; // see [RL15]
						state_r <= ST_CONV;
					end
				end
			end
			ST_CONV: begin
				if (light_s || deep_s) begin
					// power removed mid-conversion: abandon it
					hold_en <= 1'b0;
					busy_n <= 1'b1;
					ev[`AOC_IRQ_REJECT] <= 1'b1;
					state_r <= ST_IDLE;
				end else if (sar_done) begin
					result_data <= shape(sum, sat_s, out_of_span);
					hold_en <= 1'b0;
					busy_n <= 1'b1;
					ev[`AOC_IRQ_DONE] <= 1'b1;
					ev[`AOC_IRQ_RANGE] <= out_of_span;
					ev[`AOC_IRQ_EARLY] <= early_r;
					state_r <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// register file
	reg [`AOC_IRQ_W-1:0] irq_stat_r;
	reg [`AOC_IRQ_W-1:0] irq_mask_r;
	wire stat_rd = bus_rd && (bus_addr == `AOC_ADDR_IRQ_STAT);
	assign irq = |(irq_stat_r & irq_mask_r);

	always @(posedge clk) begin
		if (srst) begin
			offset_r <= `AOC_OFS_RESET;
			irq_mask_r <= {`AOC_IRQ_W{1'b0}};
			irq_stat_r <= {`AOC_IRQ_W{1'b0}};
		end else begin
			if (bus_wr && bus_addr == `AOC_ADDR_OFFSET) begin
				// top bits stored as written; nonzero is host misuse
				offset_r <= bus_wdata[`AOC_OFS_W-1:0]; // see [RL12]
			end
			if (bus_wr && bus_addr == `AOC_ADDR_IRQ_MASK) begin
				irq_mask_r <= bus_wdata[`AOC_IRQ_W-1:0];
			end
			// a new event beats the read-clear in the same cycle
			if (stat_rd) begin
				irq_stat_r <= ev;
			end else begin
				irq_stat_r <= irq_stat_r | ev;
			end
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			bus_rdata <= 32'h0000_0000;
		end else if (bus_rd) begin
			case (bus_addr)
			`AOC_ADDR_OFFSET: begin
				bus_rdata <= {{(32-`AOC_OFS_W){1'b0}}, offset_r};
			end
			`AOC_ADDR_RESULT: begin
				bus_rdata <= {{(32-`AOC_RES_W){1'b0}}, result_data};
			end
			`AOC_ADDR_IRQ_STAT: begin
				bus_rdata <= {{(32-`AOC_IRQ_W){1'b0}}, irq_stat_r};
			end
			`AOC_ADDR_IRQ_MASK: begin
				bus_rdata <= {{(32-`AOC_IRQ_W){1'b0}}, irq_mask_r};
			end
			`AOC_ADDR_STATE: begin
				bus_rdata <= {{(32-`AOC_ST_W){1'b0}}, sat_s, settled,
					~busy_n, deep_s, light_s};
			end
			default: begin
				bus_rdata <= 32'h0000_0000;
			end
			endcase
		end else begin
			bus_rdata <= 32'h0000_0000;
		end
	end

endmodule // aoc_control

// *** bench/aoc_control_assertions.sv ***
`timescale 1ns/100ps
`include "aoc_regs.vh"
module aoc_control_assertions #(
	parameter RAW_W = 16
) (
	input wire clk, // clock
	input wire srst, // reset
	input wire bus_rd, // read strobe
	input wire [31:0] bus_rdata, // read data
	input wire light_sleep_request, // light pin
	input wire deep_sleep_request, // deep pin
	input wire saturate_enable, // clamp pin
	input wire sar_done, // core done
	input wire [RAW_W-1:0] sar_raw, // raw code
	input wire core_power_en, // core power
	input wire ref_power_en, // ref power
	input wire hold_en, // hold
	input wire sar_go, // start pulse
	input wire busy_n, // busy
	input wire [`AOC_RES_W-1:0] result_data // result
);
	logic out_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// flag follows the raw input, never the clamped sum
	always @(posedge clk) out_r <= $signed(sar_raw) < 0 ||
		$signed(sar_raw) > 16383;
	sequence s_done;
		sar_done && !busy_n;
	endsequence
	sequence s_sat_done;
		saturate_enable [*8] ##0 s_done;
	endsequence
	// eight edges cover the pin filter and the power register
	a_light_ref_on: assert property ((light_sleep_request &&
		!deep_sleep_request) [*8] |-> !core_power_en && ref_power_en)
		else $error("light power wrong");
	a_deep_all_off: assert property (deep_sleep_request [*8]
		|-> !core_power_en && !ref_power_en) else $error("deep power wrong");
	a_sleep_refuse: assert property ((light_sleep_request ||
		deep_sleep_request) [*8] |-> !sar_go) else $error("start in sleep");
	a_go_pulse: assert property (sar_go |=> !sar_go)
		else $error("start pulse long");
	a_start_hold: assert property ($rose(sar_go)
		|-> hold_en && !busy_n)
		else $error("no hold at start");
	a_done_release: assert property (s_done
		|=> busy_n && !hold_en)
		else $error("busy after done");
	a_sat_flag: assert property (s_sat_done
		|=> result_data[14] == out_r)
		else $error("range flag wrong");
	a_result_hold: assert property (!(sar_done && !busy_n)
		|=> $stable(result_data)) else $error("result moved");
	a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 32'h0)
		else $error("read data not idle");
endmodule // aoc_control_assertions

// *** bench/aoc_host_model.sv ***
`timescale 1ns/100ps
module aoc_host_model #(
	parameter WAKE = 12
) (
	input wire clk, // clock
	input wire light_cmd, // ask light sleep
	input wire deep_cmd, // ask deep sleep
	input wire start_cmd, // ask conversion
	output logic light_sleep_request = 1'b0, // light pin
	output logic deep_sleep_request = 1'b0, // deep pin
	output logic sample_start_n = 1'b1 // start strobe
);
	int wait_r = 0;
	wire ready = wait_r == 0 && !light_sleep_request && !deep_sleep_request;
	always @(posedge clk) begin
		light_sleep_request <= light_cmd;
		deep_sleep_request <= deep_cmd;
		if (deep_sleep_request && !deep_cmd)
			wait_r <= WAKE;
		else if (light_sleep_request && !light_cmd)
			wait_r <= 2;
		else if (wait_r > 0)
			wait_r <= wait_r - 1;
		sample_start_n <= !(start_cmd && ready);
	end
endmodule // aoc_host_model

// *** bench/tb_aoc_control.sv ***
`timescale 1ns/100ps
`include "aoc_regs.vh"
module tb_aoc_control;
	logic clk = 1'b0, srst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
	logic saturate_enable = 1'b1, sar_done = 1'b0;
	logic light_cmd = 1'b0, deep_cmd = 1'b0, start_cmd = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0, d;
	logic [15:0] sar_raw = 16'h0;
	wire [31:0] bus_rdata;
	wire irq, light_sleep_request, deep_sleep_request, sample_start_n;
	wire core_power_en, ref_power_en, hold_en, sar_go, busy_n;
	wire [`AOC_RES_W-1:0] result_data;
	int num_errors = 0, comparisons = 0;
	aoc_control #(.DEEP_WAKE_NS(1000)) aoc_control_i (.clk(clk),
		.srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
		.light_sleep_request(light_sleep_request),
		.deep_sleep_request(deep_sleep_request),
		.saturate_enable(saturate_enable), .sample_start_n(sample_start_n),
		.sar_done(sar_done), .sar_raw(sar_raw), .core_power_en(core_power_en),
		.ref_power_en(ref_power_en), .hold_en(hold_en), .sar_go(sar_go),
		.busy_n(busy_n), .result_data(result_data));
	aoc_host_model aoc_host_model_i (.clk(clk), .light_cmd(light_cmd),
		.deep_cmd(deep_cmd), .start_cmd(start_cmd),
		.light_sleep_request(light_sleep_request),
		.deep_sleep_request(deep_sleep_request),
		.sample_start_n(sample_start_n));
	task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= v;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		d = bus_rdata;
	endtask
	// host strobe stays up until busy shows, so a wake wait is absorbed
	task conv(input logic [31:0] ofs, input logic [15:0] raw,
		input logic [14:0] e);
		int i;
		wr(`AOC_ADDR_OFFSET, ofs);
		start_cmd <= 1'b1;
		for (i = 0; i < 60 && busy_n !== 1'b0; i++) @(posedge clk);
		cmp("busy hold", 2'h1, {busy_n, hold_en});
		start_cmd <= 1'b0;
		sar_raw <= raw;
		sar_done <= 1'b1;
		@(posedge clk);
		sar_done <= 1'b0;
		@(negedge clk);
		cmp("result", e, result_data);
		repeat (6) @(posedge clk);
	endtask
	task t_reset;
		@(negedge clk);
		cmp("idle", 5'h1c, {core_power_en, ref_power_en, busy_n,
			hold_en, irq});
		rd(`AOC_ADDR_OFFSET);
		cmp("offset", 32'h0, d);
		rd(8'h14);
		cmp("unmapped", 32'h0, d);
		wr(`AOC_ADDR_OFFSET, 32'h0e00);
		rd(`AOC_ADDR_OFFSET);
		cmp("offset", 32'h0e00, d);
		$display("reset test done");
	endtask
	task t_sat;
		wr(`AOC_ADDR_IRQ_MASK, 32'h1);
		conv(32'h0, 16'h3fff, 15'h3fff);
		@(negedge clk);
		cmp("irq", 32'h1, irq);
		rd(`AOC_ADDR_IRQ_STAT);
		cmp("status", 32'h1, d & 32'h1);
		cmp("irq", 32'h0, irq);
		wr(`AOC_ADDR_IRQ_MASK, 32'h0);
		conv(32'h0, 16'h41ff, 15'h7fff);
		// done and out-of-span only; the earlier read cleared the rest
		rd(`AOC_ADDR_IRQ_STAT);
		cmp("status", 32'h3, d);
		conv(32'h0e00, 16'h3fff, 15'h3dff);
		conv(32'h0400, 16'h0, 15'h0400);
		conv(32'h0400, 16'h3fff, 15'h3fff);
		conv(32'h0e00, 16'hfae2, 15'h4000);
		rd(`AOC_ADDR_RESULT);
		cmp("result reg", 32'h4000, d);
		$display("clamp test done");
	endtask
	task t_nosat;
		@(posedge clk);
		saturate_enable <= 1'b0;
		repeat (8) @(posedge clk);
		conv(32'h0400, 16'h451e, 15'h491e);
		conv(32'h0e00, 16'hfae2, 15'h78e2);
		saturate_enable <= 1'b1;
		$display("unclamped test done");
	endtask
	task t_sleep;
		light_cmd <= 1'b1;
		repeat (10) @(posedge clk);
		@(negedge clk);
		cmp("light power", 2'h1, {core_power_en, ref_power_en});
		@(posedge clk);
		light_cmd <= 1'b0;
		conv(32'h0, 16'h0100, 15'h0100);
		deep_cmd <= 1'b1;
		repeat (10) @(posedge clk);
		rd(`AOC_ADDR_STATE);
		// clamp on, reference still waking, idle, deep only
		cmp("state", 32'h12, d & 32'h1f);
		cmp("deep power", 2'h0, {core_power_en, ref_power_en});
		@(posedge clk);
		deep_cmd <= 1'b0;
		conv(32'h0, 16'h2000, 15'h2000);
		$display("sleep test done");
	endtask
	initial forever #50 clk = ~clk;
	initial begin
		#500000;
		num_errors++;
		end_of_test;
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_sat;
		t_nosat;
		t_sleep;
		end_of_test;
	end
endmodule // tb_aoc_control
bind aoc_control aoc_control_assertions #(.RAW_W(RAW_W)) aoc_chk_i (
	.clk(clk), .srst(srst), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.light_sleep_request(light_sleep_request),
	.deep_sleep_request(deep_sleep_request),
	.saturate_enable(saturate_enable), .sar_done(sar_done),
	.sar_raw(sar_raw), .core_power_en(core_power_en),
	.ref_power_en(ref_power_en), .hold_en(hold_en), .sar_go(sar_go),
	.busy_n(busy_n), .result_data(result_data));
